// >>> retry_flow_control_pkg.sv
// Constants, register map and encodings of the retry flow control buffer
// Function
// - Retry requeues all unacknowledged packets for arbitration
// - Retried response at the resume ackID resent one priority higher, up to three
// - Responses leave in arrival order unless entry ages wrap at AGE_W bits
// - Response beats request of equal priority
// - Late arrivals join arbitration after a retry
// - One writable register holds three watermarks
// - Space is partner count minus outstanding packets
// - Hold packets whose watermark exceeds available space
// - At or above high watermark, send everything
// - Below low watermark, responses only, priority three
// - Between middle and high, hold priority 0 requests
// - No space left, stop sending
// - Queue filling raises responses-only, gates request entry
// - Receive queue strict FIFO, admission checks priority
// - Receive uses fixed per-priority reserve thresholds
// - Free 4 all, 3 p1+, 2 p2+, 1 p3 responses
// - Order: responses, p2/p3, p1, p0 requests
// - Acknowledge pointer update releases delivered packets
package retry_flow_control_pkg;

  // Register byte addresses
  localparam logic [31:0] WM_REG_ADDR     = 32'h0001_0004;
  localparam logic [31:0] STATUS_REG_ADDR = 32'h0001_0008;

  // Watermark register fields
  localparam int WM_W        = 6;
  localparam int WM_LOW_LSB  = 0;
  localparam int WM_MID_LSB  = 8;
  localparam int WM_HIGH_LSB = 16;
  localparam logic [5:0] WM_LOW_RST  = 6'h02;
  localparam logic [5:0] WM_MID_RST  = 6'h04;
  localparam logic [5:0] WM_HIGH_RST = 6'h06;

  // Status register fields
  localparam int ST_OCC_LSB   = 0;
  localparam int ST_SPACE_LSB = 8;
  localparam int ST_RONLY_BIT = 16;
  localparam int ST_UNLIM_BIT = 17;

  // Link pointer and buffer status figures
  localparam int          ACK_W      = 6;
  localparam logic [5:0]  ACK_ONE    = 6'h01;
  localparam logic [5:0]  ACK_HALF   = 6'h20;
  localparam logic [5:0]  STAT_RXFC  = 6'h3F;
  localparam logic [1:0]  PRIO_MAX   = 2'h3;
  localparam logic [1:0]  PRIO_ONE   = 2'h1;
  localparam logic [1:0]  PRIO_TWO   = 2'h2;

  // Receive reserve thresholds in free slots
  localparam logic [5:0] RX_FREE_ALL = 6'h04;
  localparam logic [5:0] RX_FREE_P1  = 6'h03;
  localparam logic [5:0] RX_FREE_P2  = 6'h02;
  localparam logic [5:0] RX_FREE_P3  = 6'h01;

  // Arbitration classes, lower wins
  localparam logic [1:0] CLS_RESP = 2'h0;
  localparam logic [1:0] CLS_HI   = 2'h1;
  localparam logic [1:0] CLS_P1   = 2'h2;
  localparam logic [1:0] CLS_P0   = 2'h3;

  // Transmit slot life cycle, Gray coded
  typedef enum logic [1:0]
  {
    SLOT_FREE   = 2'b00,
    SLOT_QUEUED = 2'b01,
    SLOT_ISSUED = 2'b11,
    SLOT_SENT   = 2'b10
  } slot_state_t;

endpackage : retry_flow_control_pkg

// >>> retry_flow_control_buffer.sv
// Transmit retry/flow-control queue, receive admission FIFO and AHB-Lite registers
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module retry_flow_control_buffer
#(
  parameter int DATA_W        = 32,
  parameter int TX_DEPTH      = 8,
  parameter int RX_DEPTH      = 8,
  parameter int RONLY_LEVEL   = 6
)
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // User transmit side
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic [1:0]        tx_prio,
  input  wire logic              tx_is_resp,
  output logic                   responses_only,
  // Link transmit side
  output logic                   link_valid,
  input  wire logic              link_ready,
  output logic [DATA_W-1:0]      link_data,
  output logic [1:0]             link_prio,
  output logic                   link_is_resp,
  input  wire logic [5:0]        next_frame_ackid,
  input  wire logic [5:0]        last_ack_ackid,
  input  wire logic              link_rewind,
  input  wire logic [5:0]        partner_buf_stat,
  // Link receive side
  input  wire logic              rx_in_valid,
  input  wire logic [DATA_W-1:0] rx_in_data,
  input  wire logic [1:0]        rx_in_prio,
  input  wire logic              rx_in_is_resp,
  output logic                   rx_in_retry,
  output logic [5:0]             rx_buf_stat,
  // User receive side
  output logic                   rx_out_valid,
  input  wire logic              rx_out_ready,
  output logic [DATA_W-1:0]      rx_out_data,
  output logic [1:0]             rx_out_prio,
  output logic                   rx_out_is_resp
);

  localparam int TI_W  = $clog2(TX_DEPTH);
  localparam int AGE_W = TI_W + 1;
  localparam int RI_W  = $clog2(RX_DEPTH);

  // ==
  // Helper functions
  // Arbitration class of a packet
  function automatic logic [1:0] class_of(input logic resp, input logic [1:0] prio);
    if (resp)
      return retry_flow_control_pkg::CLS_RESP;
    else if (prio >= retry_flow_control_pkg::PRIO_TWO)
      return retry_flow_control_pkg::CLS_HI;
    else if (prio == retry_flow_control_pkg::PRIO_ONE)
      return retry_flow_control_pkg::CLS_P1;
    else
      return retry_flow_control_pkg::CLS_P0;
  endfunction : class_of

  // Acknowledged when the ackID lies at or before the last ack
  function automatic logic delivered(input logic [5:0] ack, input logic [5:0] last);
    return (6'(last - ack) < retry_flow_control_pkg::ACK_HALF);
  endfunction : delivered

  // Fixed receive reserve: one slot kept per priority step
  function automatic logic rx_admit(input logic [5:0] free, input logic [1:0] prio, input logic resp);
    if (free >= retry_flow_control_pkg::RX_FREE_ALL)
      return 1'b1;
    else if (free == retry_flow_control_pkg::RX_FREE_P1)
      return (prio >= retry_flow_control_pkg::PRIO_ONE);
    else if (free == retry_flow_control_pkg::RX_FREE_P2)
      return (prio >= retry_flow_control_pkg::PRIO_TWO);
    else if (free == retry_flow_control_pkg::RX_FREE_P3)
      return (prio == retry_flow_control_pkg::PRIO_MAX) && resp;
    else
      return 1'b0;
  endfunction : rx_admit

  // ==
  // Register bus
  localparam int WM_W_C = retry_flow_control_pkg::WM_W;
  logic [5:0]  wm_low_q, wm_middle_q, wm_high_q;
  logic        wr_pend_q;
  logic [31:0] wr_addr_q;
  logic        bus_take;
  logic [31:0] rd_word;

  assign bus_take  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Write data arrives one cycle after its address phase
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= bus_take && hwrite;
      wr_addr_q <= haddr;
    end

  // Watermark register, whole-word layout
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      wm_low_q    <= retry_flow_control_pkg::WM_LOW_RST;
      wm_middle_q <= retry_flow_control_pkg::WM_MID_RST;
      wm_high_q   <= retry_flow_control_pkg::WM_HIGH_RST;
    end
    else if (wr_pend_q && wr_addr_q == retry_flow_control_pkg::WM_REG_ADDR)
    begin
      wm_low_q    <= hwdata[retry_flow_control_pkg::WM_LOW_LSB +: WM_W_C];
      wm_middle_q <= hwdata[retry_flow_control_pkg::WM_MID_LSB +: WM_W_C];
      wm_high_q   <= hwdata[retry_flow_control_pkg::WM_HIGH_LSB +: WM_W_C];
    end

  // ==
  // Transmit space accounting
  logic [5:0]        outstanding;
  logic signed [7:0] space;
  logic              unlimited;
  logic [5:0]        occ;

  assign outstanding = 6'(next_frame_ackid - last_ack_ackid - retry_flow_control_pkg::ACK_ONE);
  assign space       = $signed({2'b00, partner_buf_stat}) - $signed({2'b00, outstanding});
  // All-ones status means the partner runs receiver-controlled only
  assign unlimited   = (partner_buf_stat == retry_flow_control_pkg::STAT_RXFC);

  // Read mux, answered in the data phase from registered data
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (haddr == retry_flow_control_pkg::WM_REG_ADDR)
    begin
      rd_word[retry_flow_control_pkg::WM_LOW_LSB +: WM_W_C]  = wm_low_q;
      rd_word[retry_flow_control_pkg::WM_MID_LSB +: WM_W_C]  = wm_middle_q;
      rd_word[retry_flow_control_pkg::WM_HIGH_LSB +: WM_W_C] = wm_high_q;
    end
    else if (haddr == retry_flow_control_pkg::STATUS_REG_ADDR)
    begin
      rd_word[retry_flow_control_pkg::ST_OCC_LSB +: 6]   = occ;
      rd_word[retry_flow_control_pkg::ST_SPACE_LSB +: 8] = space;
      rd_word[retry_flow_control_pkg::ST_RONLY_BIT]      = responses_only;
      rd_word[retry_flow_control_pkg::ST_UNLIM_BIT]      = unlimited;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (bus_take && !hwrite)
      hrdata <= rd_word;

  // ==
  // Transmit slots
  typedef retry_flow_control_pkg::slot_state_t slot_t;
  slot_t             st_q   [TX_DEPTH];
  logic [DATA_W-1:0] d_q    [TX_DEPTH];
  logic [1:0]        prio_q [TX_DEPTH];
  logic              resp_q [TX_DEPTH];
  logic [AGE_W-1:0]  age_q  [TX_DEPTH];
  logic [5:0]        ack_q  [TX_DEPTH];
  logic [TI_W-1:0]   issue_idx_q;
  logic              rewind_q;
  logic              rewind_end;
  logic              tx_take;
  logic              have_free;
  logic [TI_W-1:0]   free_idx;
  logic              found;
  logic [TI_W-1:0]   pick_idx;
  logic              pick;
  logic              link_take;

  assign rewind_end = rewind_q && !link_rewind;
  assign link_take  = link_valid && link_ready;
  assign tx_ready   = have_free && (!responses_only || tx_is_resp);
  assign tx_take    = tx_valid && tx_ready;
  assign pick       = found && !link_valid && !link_rewind && !rewind_q;

  // Free slot search, occupancy and arbitration
  always_comb
  begin
    logic [1:0]       bcls;
    logic [AGE_W-1:0] bage;
    logic [1:0]       c;
    logic             ok;
    c         = 2'h0;
    ok        = 1'b0;
    have_free = 1'b0;
    free_idx  = '0;
    found     = 1'b0;
    pick_idx  = '0;
    occ       = 6'h00;
    bcls      = 2'h0;
    bage      = '0;
    for (int i = TX_DEPTH - 1; i >= 0; i--)
    begin
      if (st_q[i] == retry_flow_control_pkg::SLOT_FREE)
      begin
        have_free = 1'b1;
        free_idx  = TI_W'(i);
      end
      else
        occ = 6'(occ + 6'h01);
    end
    for (int i = 0; i < TX_DEPTH; i++)
    begin
      c = class_of(resp_q[i], prio_q[i]);
      // Watermark gate per class
      if (unlimited)
        ok = 1'b1;
      else if (space <= 8'sd0)
        ok = 1'b0;
      else if (c == retry_flow_control_pkg::CLS_RESP)
        ok = 1'b1;
      else if (c == retry_flow_control_pkg::CLS_HI)
        ok = (space >= $signed({2'b00, wm_low_q}));
      else if (c == retry_flow_control_pkg::CLS_P1)
        ok = (space >= $signed({2'b00, wm_middle_q}));
      else
        ok = (space >= $signed({2'b00, wm_high_q}));
      // Class first, then oldest within class
      if (st_q[i] == retry_flow_control_pkg::SLOT_QUEUED && ok &&
          (!found || c < bcls || (c == bcls && age_q[i] > bage)))
      begin
        found    = 1'b1;
        pick_idx = TI_W'(i);
        bcls     = c;
        bage     = age_q[i];
      end
    end
  end

  // Slot life cycle: enter, issue, ack, release, requeue
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      for (int i = 0; i < TX_DEPTH; i++)
      begin
        st_q[i]   <= retry_flow_control_pkg::SLOT_FREE;
        d_q[i]    <= '0;
        prio_q[i] <= 2'h0;
        resp_q[i] <= 1'b0;
        age_q[i]  <= '0;
        ack_q[i]  <= 6'h00;
      end
    end
    else
    begin
      for (int i = 0; i < TX_DEPTH; i++)
      begin
        // Ages only grow on entry; they wrap at AGE_W bits, so a long-held slot can tie with a new one
        if (tx_take && st_q[i] != retry_flow_control_pkg::SLOT_FREE)
          age_q[i] <= AGE_W'(age_q[i] + 1'b1);
        if (st_q[i] == retry_flow_control_pkg::SLOT_SENT && !link_rewind && !rewind_q &&
            delivered(ack_q[i], last_ack_ackid))
          st_q[i] <= retry_flow_control_pkg::SLOT_FREE;
        else if (st_q[i] == retry_flow_control_pkg::SLOT_SENT && rewind_end)
        begin
          // Pointers are settled once the rewind drops
          if (delivered(ack_q[i], last_ack_ackid))
            st_q[i] <= retry_flow_control_pkg::SLOT_FREE;
          else
            st_q[i] <= retry_flow_control_pkg::SLOT_QUEUED;
          if (!delivered(ack_q[i], last_ack_ackid) && ack_q[i] == next_frame_ackid &&
              resp_q[i] && prio_q[i] != retry_flow_control_pkg::PRIO_MAX)
            prio_q[i] <= 2'(prio_q[i] + 2'h1);
        end
      end
      if (pick)
        st_q[pick_idx] <= retry_flow_control_pkg::SLOT_ISSUED;
      if (link_take)
      begin
        st_q[issue_idx_q]  <= retry_flow_control_pkg::SLOT_SENT;
        ack_q[issue_idx_q] <= next_frame_ackid;
      end
      // New packets are plain queued slots, so they arbitrate too
      if (tx_take)
      begin
        st_q[free_idx]   <= retry_flow_control_pkg::SLOT_QUEUED;
        d_q[free_idx]    <= tx_data;
        prio_q[free_idx] <= tx_prio;
        resp_q[free_idx] <= tx_is_resp;
        age_q[free_idx]  <= '0;
      end
    end

  // Output stage; one bubble between packets keeps ackID capture simple
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      link_valid   <= 1'b0;
      link_data    <= '0;
      link_prio    <= 2'h0;
      link_is_resp <= 1'b0;
      issue_idx_q  <= '0;
    end
    else if (pick)
    begin
      link_valid   <= 1'b1;
      link_data    <= d_q[pick_idx];
      link_is_resp <= resp_q[pick_idx];
      issue_idx_q  <= pick_idx;
      if (resp_q[pick_idx] && !unlimited && space < $signed({2'b00, wm_low_q}))
        link_prio <= retry_flow_control_pkg::PRIO_MAX;
      else
        link_prio <= prio_q[pick_idx];
    end
    else if (link_take)
      link_valid <= 1'b0;

  // Rewind edge and responses-only flag
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      rewind_q       <= 1'b0;
      responses_only <= 1'b0;
    end
    else
    begin
      rewind_q       <= link_rewind;
      responses_only <= (occ >= 6'(RONLY_LEVEL));
    end

  // ==
  // Receive FIFO with fixed reserve admission
  logic [DATA_W-1:0] rd_q   [RX_DEPTH];
  logic [1:0]        rp_q   [RX_DEPTH];
  logic              rr_q   [RX_DEPTH];
  logic [RI_W:0]     rx_wp_q, rx_rp_q;
  logic [5:0]        rx_free;
  logic              rx_acc;
  logic              rx_pop;

  assign rx_free     = 6'(RX_DEPTH) - 6'(rx_wp_q - rx_rp_q);
  assign rx_acc      = rx_in_valid && rx_admit(rx_free, rx_in_prio, rx_in_is_resp);
  assign rx_pop      = rx_out_valid && rx_out_ready;
  assign rx_out_valid = (rx_wp_q != rx_rp_q);
  assign rx_out_data  = rd_q[rx_rp_q[RI_W-1:0]];
  assign rx_out_prio  = rp_q[rx_rp_q[RI_W-1:0]];
  assign rx_out_is_resp = rr_q[rx_rp_q[RI_W-1:0]];

  // Strict FIFO order, refused packets flagged for retry
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      rx_wp_q     <= '0;
      rx_rp_q     <= '0;
      rx_in_retry <= 1'b0;
      rx_buf_stat <= 6'h00;
      for (int i = 0; i < RX_DEPTH; i++)
      begin
        rd_q[i] <= '0;
        rp_q[i] <= 2'h0;
        rr_q[i] <= 1'b0;
      end
    end
    else
    begin
      rx_in_retry <= rx_in_valid && !rx_acc;
      rx_buf_stat <= rx_free;
      if (rx_acc)
      begin
        rd_q[rx_wp_q[RI_W-1:0]] <= rx_in_data;
        rp_q[rx_wp_q[RI_W-1:0]] <= rx_in_prio;
        rr_q[rx_wp_q[RI_W-1:0]] <= rx_in_is_resp;
        rx_wp_q <= (RI_W+1)'(rx_wp_q + 1'b1);
      end
      if (rx_pop)
        rx_rp_q <= (RI_W+1)'(rx_rp_q + 1'b1);
    end

endmodule : retry_flow_control_buffer
`default_nettype wire

// >>> phy_link_model.sv
// Link-side partner: takes packets and acknowledges them at once
`timescale 1ns/1ns
`default_nettype none
module phy_link_model
(
  input  wire logic   clock,
  input  wire logic   sys_rst,
  input  wire logic   hold,
  input  wire logic   link_rewind,
  input  wire logic   stall_ack,
  input  wire logic   link_valid,
  output logic        link_ready,
  output logic [5:0]  next_frame_ackid,
  output logic [5:0]  last_ack_ackid
);
  // ==
  // Acceptance and ackID pointers
  // Stalls only when the bench asks, to exercise the hold rule
  assign link_ready = !hold;
  // Immediate acknowledge keeps outstanding count at zero between packets
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      next_frame_ackid <= 6'h00;
      last_ack_ackid   <= 6'h3F;
    end
    else if (link_rewind)
      next_frame_ackid <= last_ack_ackid + 6'h01;
    else if (link_valid && link_ready)
    begin
      next_frame_ackid <= next_frame_ackid + 6'h01;
      last_ack_ackid   <= stall_ack ? last_ack_ackid : next_frame_ackid;
    end
  end
endmodule : phy_link_model
`default_nettype wire

// >>> retry_flow_control_buffer_asserts.sv
// Port checker for the retry flow control buffer
`timescale 1ns/1ns
`default_nettype none
module retry_flow_control_checker
#(
  parameter int DATA_W = 32
)
(
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              tx_ready,
  input wire logic              tx_is_resp,
  input wire logic              responses_only,
  input wire logic              link_valid,
  input wire logic              link_ready,
  input wire logic [DATA_W-1:0] link_data,
  input wire logic [1:0]        link_prio,
  input wire logic              link_is_resp,
  input wire logic [5:0]        next_frame_ackid,
  input wire logic [5:0]        last_ack_ackid,
  input wire logic [5:0]        partner_buf_stat,
  input wire logic              rx_in_valid,
  input wire logic [1:0]        rx_in_prio,
  input wire logic              rx_in_is_resp,
  input wire logic              rx_in_retry,
  input wire logic [5:0]        rx_buf_stat
);
  // ==
  // Helpers
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic              wr_q;
  logic [31:0]       wm_q;
  logic [5:0]        outst;
  logic signed [7:0] space;
  logic              unlim, can_send, ok_lo, ok_mid, ok_hi, rx_ok;
  // Watermark shadow, written as the data phase ends
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      wr_q <= 1'b0;
    else
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr == retry_flow_control_pkg::WM_REG_ADDR;
  end
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      wm_q <= 32'h0006_0402;
    else if (wr_q && hready)
      wm_q <= hwdata;
  end
  // Space reckoned signed, so a stale partner count cannot wrap to plenty
  assign outst = next_frame_ackid - last_ack_ackid - 6'h01;
  assign space = $signed({2'h0, partner_buf_stat}) - $signed({2'h0, outst});
  assign unlim = partner_buf_stat == retry_flow_control_pkg::STAT_RXFC;
  assign can_send = unlim || space > 8'sh00;
  assign ok_lo = unlim || space >= $signed({2'h0, wm_q[5:0]});
  assign ok_mid = unlim || space >= $signed({2'h0, wm_q[13:8]});
  assign ok_hi = unlim || space >= $signed({2'h0, wm_q[21:16]});
  assign rx_ok = rx_buf_stat >= 6'h04 || (rx_buf_stat == 6'h03 && rx_in_prio != 2'h0)
                 || (rx_buf_stat == 6'h02 && rx_in_prio[1]) || (rx_buf_stat == 6'h01 && rx_in_prio == 2'h3 && rx_in_is_resp);
  // ==
  // Assertions
  ahb_zero_wait_a:
    assert property (hreadyout) else $error("bus slave inserted a wait state");
  ahb_okay_a:
    assert property (!hresp) else $error("bus slave answered with an error");
  link_hold_a:
    assert property (link_valid && !link_ready |=> link_valid && $stable(link_data) && $stable(link_prio))
      else $error("link packet changed before it was taken");
  link_bubble_a:
    assert property (link_valid && link_ready |=> !link_valid) else $error("link valid stayed up after a take");
  no_space_a:
    assert property ($rose(link_valid) |-> $past(can_send)) else $error("packet offered with no partner space");
  req_gate_a:
    assert property ($rose(link_valid) && !link_is_resp |-> $past(ok_lo) && (link_prio[1] || $past(ok_mid))
      && (link_prio != 2'h0 || $past(ok_hi))) else $error("request offered below its watermark");
  resp_bump_a:
    assert property ($rose(link_valid) && link_is_resp && !$past(ok_lo) |-> link_prio == 2'h3)
      else $error("response below low watermark not raised to three");
  rx_admit_a:
    assert property (rx_in_valid |=> rx_in_retry != $past(rx_ok)) else $error("receive admission wrong");
  ronly_gate_a:
    assert property (responses_only && !tx_is_resp |-> !tx_ready) else $error("request taken in responses-only");
  cover property ($rose(link_valid) && link_is_resp);
  cover property (rx_in_retry);
  cover property ($rose(responses_only));
endmodule : retry_flow_control_checker
bind retry_flow_control_buffer retry_flow_control_checker #(.DATA_W(DATA_W)) i_chk (.*);
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the retry flow control buffer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==
  // Signals
  localparam logic [31:0] WM = retry_flow_control_pkg::WM_REG_ADDR;
  logic        clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, hold, link_rewind, stall_ack;
  logic [1:0]  htrans, tx_prio, link_prio, rx_in_prio, rx_out_prio;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, tx_data, link_data, rx_in_data, rx_out_data;
  logic        tx_valid, tx_ready, tx_is_resp, responses_only, link_valid, link_ready, link_is_resp;
  logic        rx_in_valid, rx_in_is_resp, rx_in_retry, rx_out_valid, rx_out_ready, rx_out_is_resp;
  logic [5:0]  next_frame_ackid, last_ack_ackid, partner_buf_stat, rx_buf_stat;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  // Slave ready is the bus ready
  assign hready = hreadyout;
  retry_flow_control_buffer i_dut (.*);
  phy_link_model i_phy (.*);
  // ==
  // Clock and hang guard
  initial clock = 1'b0;
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      miscompares++;
      complete_run();
    end
  end
  // ==
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask : chk
  // Single word; data taken at the second ready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : ahb
  task automatic send(input logic [31:0] d, input logic [1:0] p, input logic r);
    @(posedge clock);
    tx_valid <= 1'b1;
    tx_data <= d;
    tx_prio <= p;
    tx_is_resp <= r;
    do @(negedge clock); while (tx_ready !== 1'b1);
    @(posedge clock);
    tx_valid <= 1'b0;
  endtask : send
  task automatic take(input logic [31:0] d, input logic [1:0] p);
    int n = 0;
    do begin @(negedge clock); n++; end while (!(link_valid === 1'b1 && link_ready === 1'b1) && n < 60);
    chk("link_data", d, link_data);
    chk("link_prio", 32'(p), 32'(link_prio));
    @(posedge clock);
  endtask : take
  task automatic quiet();
    logic seen = 1'b0;
    repeat (20) begin @(negedge clock); if (link_valid !== 1'b0) seen = 1'b1; end
    chk("link_idle", 32'h0, 32'(seen));
  endtask : quiet
  // ==
  // Scenarios
  task automatic reg_test();
    logic [31:0] rd;
    ahb(1'b0, WM, 32'h0, rd);
    chk("wm_reset", 32'h0006_0402, rd);
    ahb(1'b1, WM, 32'h000A_0703, rd);
    ahb(1'b0, WM, 32'h0, rd);
    chk("wm_back", 32'h000A_0703, rd);
    ahb(1'b0, 32'h0001_0010, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, WM, 32'h0006_0402, rd);
  endtask : reg_test
  // Zero space, then release behind a stall
  task automatic arb_test();
    partner_buf_stat <= 6'h00;
    send(32'hA0, 2'h0, 1'b0);
    send(32'hA1, 2'h1, 1'b0);
    send(32'hA2, 2'h2, 1'b0);
    send(32'hA3, 2'h1, 1'b1);
    send(32'hA4, 2'h0, 1'b1);
    quiet();
    partner_buf_stat <= 6'h3F;
    hold <= 1'b1;
    repeat (5) @(posedge clock);
    hold <= 1'b0;
    take(32'hA3, 2'h1);
    take(32'hA4, 2'h0);
    take(32'hA2, 2'h2);
    take(32'hA1, 2'h1);
    take(32'hA0, 2'h0);
  endtask : arb_test
  // Watermarks 2/4/6; nothing outstanding, space is partner status
  task automatic wm_test();
    partner_buf_stat <= 6'h03;
    send(32'hB0, 2'h0, 1'b0);
    send(32'hB1, 2'h1, 1'b0);
    send(32'hB2, 2'h2, 1'b0);
    take(32'hB2, 2'h2);
    quiet();
    partner_buf_stat <= 6'h05;
    take(32'hB1, 2'h1);
    quiet();
    partner_buf_stat <= 6'h01;
    send(32'hB3, 2'h0, 1'b1);
    take(32'hB3, 2'h3);
    partner_buf_stat <= 6'h06;
    take(32'hB0, 2'h0);
  endtask : wm_test
  task automatic ronly_test();
    partner_buf_stat <= 6'h00;
    for (int i = 0; i < 6; i++) send(32'hC0 + 32'(i), 2'h2, 1'b0);
    repeat (2) @(posedge clock);
    chk("responses_only", 32'h1, 32'(responses_only));
    tx_valid <= 1'b1;
    tx_is_resp <= 1'b0;
    repeat (2) @(posedge clock);
    chk("tx_ready_req", 32'h0, 32'(tx_ready));
    tx_valid <= 1'b0;
    send(32'hC6, 2'h0, 1'b1);
    partner_buf_stat <= 6'h3F;
    take(32'hC6, 2'h0);
    for (int i = 0; i < 6; i++) take(32'hC0 + 32'(i), 2'h2);
    repeat (4) @(posedge clock);
    chk("responses_only", 32'h0, 32'(responses_only));
  endtask : ronly_test
  // Unacked pair retried: both requeue, response bumped
  task automatic retry_test();
    stall_ack <= 1'b1;
    send(32'hD0, 2'h1, 1'b1);
    take(32'hD0, 2'h1);
    send(32'hD1, 2'h0, 1'b0);
    take(32'hD1, 2'h0);
    link_rewind <= 1'b1;
    repeat (2) @(posedge clock);
    {link_rewind, stall_ack} <= 2'b00;
    take(32'hD0, 2'h2);
    take(32'hD1, 2'h0);
  endtask : retry_test
  // Offers {resp, prio, refused}, free count eight to zero
  task automatic rx_test();
    logic [3:0]  ofr [12] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'hE, 4'hF};
    logic [31:0] q [$];
    chk("rx_free", 32'h8, 32'(rx_buf_stat));
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clock);
      rx_in_valid <= 1'b1;
      rx_in_data <= 32'(i);
      rx_in_prio <= ofr[i][2:1];
      rx_in_is_resp <= ofr[i][3];
      @(posedge clock);
      rx_in_valid <= 1'b0;
      rx_in_data <= ~32'(i);
      @(negedge clock);
      chk("rx_in_retry", 32'(ofr[i][0]), 32'(rx_in_retry));
      if (!ofr[i][0]) q.push_back(32'(i));
      repeat (2) @(posedge clock);
    end
    chk("rx_full", 32'h0, 32'(rx_buf_stat));
    rx_out_ready <= 1'b1;
    foreach (q[k])
    begin
      do @(negedge clock); while (rx_out_valid !== 1'b1);
      chk("rx_out_data", q[k], rx_out_data);
      @(posedge clock);
    end
    rx_out_ready <= 1'b0;
    repeat (4) @(posedge clock);
    chk("rx_free", 32'h8, 32'(rx_buf_stat));
  endtask : rx_test
  // ==
  // Main sequence
  initial
  begin
    {sys_rst, hold, link_rewind, stall_ack} = 4'h8;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = {4'h0, 3'h2, 64'h0};
    {tx_valid, tx_is_resp, tx_prio, tx_data} = 36'h0;
    {rx_in_valid, rx_in_is_resp, rx_in_prio, rx_in_data, rx_out_ready} = 37'h0;
    partner_buf_stat = 6'h3F;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    reg_test();
    arb_test();
    wm_test();
    ronly_test();
    retry_test();
    rx_test();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
